// File: ifmwc_cfg.svh
// Register offsets, field positions, reset values and counts of the block.
// Functional notes
// - Start-fail flag on failed start, reservation off
// - Busy flag: start, or enable with ise=0, sets; stop clears
// - Initial start enable gates first start condition
// - Reservation disable bit switches reservation function
// - Flag bits 7,6 read-only, 5..2 zero
// - Wakeup enable runs address-match wakeup in STOP
// - Wakeup suppresses stop interrupt, keeps match interrupts
// - Software wakeup clear blocks master until start/stop
// - Clock line level readable while enabled
// - Data line level readable while enabled
// - Speed select picks standard or fast mode
// - Noise filter only in fast mode
// - Low width register sets low time, hold
// - High width register sets high time
// - Direction bits: 0 output, 1 input
// - Pins driven low while controller disabled
// - Both pins open drain with input path
// - Reset values 00H and FFH
// - Hold time counts upper six low-width bits
`ifndef IFMWC_CFG_SVH
`define IFMWC_CFG_SVH
`define IFMWC_ADDR_PORT6 16'hff26
`define IFMWC_ADDR_MODE 16'hffa9
`define IFMWC_ADDR_FLAG 16'hffaa
`define IFMWC_ADDR_WL 16'hffae
`define IFMWC_ADDR_WH 16'hffaf
`define IFMWC_RST_PORT6 8'hff
`define IFMWC_RST_MODE 8'h00
`define IFMWC_RST_FLAG 8'h00
`define IFMWC_RST_WL 8'hff
`define IFMWC_RST_WH 8'hff
`define IFMWC_PORT6_FIXED 8'hfc
`define IFMWC_F_FAIL 7
`define IFMWC_F_BUSY 6
`define IFMWC_F_ISE 1
`define IFMWC_F_RSV 0
`define IFMWC_M_WUP 7
`define IFMWC_M_CLD 5
`define IFMWC_M_DAD 4
`define IFMWC_M_SMC 3
`define IFMWC_M_DFC 2
`define IFMWC_P_SCL 0
`define IFMWC_P_SDA 1
`define IFMWC_FILT_LEN 2'h3
`endif

// File: ifmwc_pkg.sv
// Types shared by the controller files: clock states and state records.
package ifmwc_pkg;
  // Master clock generator phases.
  typedef enum logic [2:0] {
    CG_IDLE = 3'b001,
    CG_LOW = 3'b010,
    CG_HIGH = 3'b100
  } ifmwc_clk_e;

  // Whole state of the link-side sampler.
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic flt_s1;
    logic flt_s2;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_cnt;
    logic [1:0] sda_cnt;
    logic start_tgl;
    logic stop_tgl;
  } ifmwc_link_s;

  // Whole state of the register and control side.
  typedef struct packed {
    logic [7:0] port6;
    logic wakeup_enable;
    logic smc;
    logic dfc;
    logic cld;
    logic dad;
    logic fail;
    logic busy;
    logic ise;
    logic rsv;
    logic [7:0] wl;
    logic [7:0] wh;
    logic [7:0] rdata;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic st_s1;
    logic st_s2;
    logic st_d;
    logic sp_s1;
    logic sp_s2;
    logic sp_d;
    logic en_d;
    logic start_ok;
    logic mst_block;
    logic wup_irq_seen;
    logic start_allowed;
    logic flt_on;
    ifmwc_clk_e cg;
    logic [7:0] cg_cnt;
    logic [5:0] hold_cnt;
    logic hold_done;
    logic sda_pull;
    logic scl_oe;
    logic sda_oe;
    logic int_req;
    logic wake_req;
  } ifmwc_top_s;
endpackage : ifmwc_pkg

// File: ifmwc_link.sv
// Link-side pin sampler: synchroniser, noise filter, start and stop detect.
`timescale 1ns/1ps
`include "ifmwc_cfg.svh"
module ifmwc_link import ifmwc_pkg::*; (
  input wire logic link_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic filter_on,
  output logic scl_lvl,
  output logic sda_lvl,
  output logic start_tgl,
  output logic stop_tgl
);
  ifmwc_link_s s; // Registered state.
  ifmwc_link_s n; // Next state.

  // Pins pass two flops, then an optional stability filter, then detection.
  always_comb begin
    n = s;
    n.scl_s1 = scl_in;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = sda_in;
    n.sda_s2 = s.sda_s1;
    n.flt_s1 = filter_on;
    n.flt_s2 = s.flt_s1;
    // With the filter on, a new level is accepted only after it stands for several samples.
    if (s.scl_s2 == s.scl_f) begin
      n.scl_cnt = 2'h0;
    end else if (!s.flt_s2 || s.scl_cnt == `IFMWC_FILT_LEN) begin
      n.scl_f = s.scl_s2;
      n.scl_cnt = 2'h0;
    end else begin
      n.scl_cnt = s.scl_cnt + 2'h1;
    end
    if (s.sda_s2 == s.sda_f) begin
      n.sda_cnt = 2'h0;
    end else if (!s.flt_s2 || s.sda_cnt == `IFMWC_FILT_LEN) begin
      n.sda_f = s.sda_s2;
      n.sda_cnt = 2'h0;
    end else begin
      n.sda_cnt = s.sda_cnt + 2'h1;
    end
    // Data falling while clock is high is a start; rising is a stop.
    if (s.scl_f && n.scl_f && s.sda_f && !n.sda_f) begin
      n.start_tgl = ~s.start_tgl;
    end
    if (s.scl_f && n.scl_f && !s.sda_f && n.sda_f) begin
      n.stop_tgl = ~s.stop_tgl;
    end
  end

  // State register; the bus idles high after reset.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             scl_f: 1'b1, sda_f: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign scl_lvl = s.scl_f;
  assign sda_lvl = s.sda_f;
  assign start_tgl = s.start_tgl;
  assign stop_tgl = s.stop_tgl;
endmodule : ifmwc_link

// File: ifmwc_top.sv
// Flag, mode and width registers with master clock timing and pin control.
`timescale 1ns/1ps
`include "ifmwc_cfg.svh"
module ifmwc_top import ifmwc_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic LINK_CLK,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] WMASK,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CTRL_ENABLE,
  input wire logic START_REQ,
  input wire logic START_FAIL,
  input wire logic STOP_MODE,
  input wire logic ADDR_MATCH_EVT,
  input wire logic EXT_CODE_EVT,
  input wire logic STOP_INT_EN,
  input wire logic MASTER_CLK_RUN,
  input wire logic DATA_PULL_LOW,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic BUS_BUSY,
  output logic START_ALLOWED,
  output logic RESERVATION_EN,
  output logic FAST_MODE,
  output logic DATA_HOLD_DONE,
  output logic INT_REQ,
  output logic WAKEUP_REQ
);
  ifmwc_top_s s; // Registered state.
  ifmwc_top_s n; // Next state.
  logic link_scl; // Filtered clock line level, link domain.
  logic link_sda; // Filtered data line level, link domain.
  logic link_st; // Start toggle, link domain.
  logic link_sp; // Stop toggle, link domain.

  // Merges written bits into an old value under a bit mask.
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] val,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction : merge

  // The pin sampler runs on the link clock.
  ifmwc_link u_link (
    .link_clk(LINK_CLK),
    .rst_b(RST_B),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .filter_on(s.flt_on),
    .scl_lvl(link_scl),
    .sda_lvl(link_sda),
    .start_tgl(link_st),
    .stop_tgl(link_sp)
  );

  // Next-state logic for registers, flags, clock timing and pins.
  always_comb begin
    logic start_det;
    logic stop_det;
    logic en_rise;
    logic [7:0] wv;
    logic [7:0] fl;
    logic [7:0] md;
    logic [5:0] hold_tgt;
    start_det = 1'b0;
    stop_det = 1'b0;
    en_rise = 1'b0;
    wv = 8'h00;
    fl = 8'h00;
    md = 8'h00;
    hold_tgt = 6'h00;
    n = s;

    // Levels cross through two flops; events cross as toggles.
    n.scl_s1 = link_scl;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = link_sda;
    n.sda_s2 = s.sda_s1;
    n.st_s1 = link_st;
    n.st_s2 = s.st_s1;
    n.st_d = s.st_s2;
    n.sp_s1 = link_sp;
    n.sp_s2 = s.sp_s1;
    n.sp_d = s.sp_s2;
    start_det = s.st_s2 ^ s.st_d;
    stop_det = s.sp_s2 ^ s.sp_d;
    n.en_d = CTRL_ENABLE;
    en_rise = CTRL_ENABLE & ~s.en_d;

    // A start on the bus drops the initial start enable.
    if (start_det) begin
      n.ise = 1'b0;
    end

    // Register writes; bit writes arrive as a partial mask.
    if (WR) begin
      case (ADDR)
        `IFMWC_ADDR_FLAG: begin
          // Only the two low bits take writes, and only while disabled.
          wv = merge({6'h00, s.ise, s.rsv}, WDATA, WMASK);
          if (!CTRL_ENABLE) begin
            n.ise = wv[`IFMWC_F_ISE];
            n.rsv = wv[`IFMWC_F_RSV];
          end
        end
        `IFMWC_ADDR_MODE: begin
          // Old value laid out on the register's own bit positions.
          wv = merge({s.wakeup_enable, 3'h0, s.smc, s.dfc, 2'h0}, WDATA, WMASK);
          n.wakeup_enable = wv[`IFMWC_M_WUP];
          // Software clear with no wakeup interrupt blocks the master.
          if (s.wakeup_enable && !wv[`IFMWC_M_WUP] && !s.wup_irq_seen) begin
            n.mst_block = 1'b1;
          end
          if (!s.wakeup_enable && wv[`IFMWC_M_WUP]) begin
            n.wup_irq_seen = 1'b0;
          end
          if (!CTRL_ENABLE) begin
            n.smc = wv[`IFMWC_M_SMC];
            n.dfc = wv[`IFMWC_M_DFC];
          end
        end
        `IFMWC_ADDR_WL: begin
          if (!CTRL_ENABLE) begin
            n.wl = merge(s.wl, WDATA, WMASK);
          end
        end
        `IFMWC_ADDR_WH: begin
          if (!CTRL_ENABLE) begin
            n.wh = merge(s.wh, WDATA, WMASK);
          end
        end
        `IFMWC_ADDR_PORT6: begin
          // Upper six direction bits always stay at one.
          n.port6 = merge(s.port6, WDATA, WMASK) | `IFMWC_PORT6_FIXED;
        end
        default: begin
          n.port6 = s.port6; // Unmapped writes are dropped.
        end
      endcase
    end

    // Start-fail flag: clears on a start request or disable; set wins.
    if (START_REQ || !CTRL_ENABLE) begin
      n.fail = 1'b0;
    end
    if (CTRL_ENABLE && START_FAIL && s.rsv) begin
      n.fail = 1'b1;
    end

    // Bus busy: stop or disable clears, start or enable with ise=0 sets.
    if (stop_det || !CTRL_ENABLE) begin
      n.busy = 1'b0;
    end
    if (CTRL_ENABLE && (start_det || (en_rise && !s.ise))) begin
      n.busy = 1'b1;
    end

    // First start is allowed at once with ise=1, else after a stop.
    if (!CTRL_ENABLE) begin
      n.start_ok = 1'b0;
    end else if (en_rise) begin
      n.start_ok = s.ise | stop_det;
    end else if (stop_det) begin
      n.start_ok = 1'b1;
    end

    // Master block after a software wakeup clear ends at start or stop.
    if (start_det || stop_det) begin
      n.mst_block = 1'b0;
    end
    n.start_allowed = CTRL_ENABLE & n.start_ok & ~n.mst_block;

    // Line levels read zero while the controller is off.
    n.cld = CTRL_ENABLE & s.scl_s2;
    n.dad = CTRL_ENABLE & s.sda_s2;

    // Filter is armed only when fast mode and filter bit are both on.
    n.flt_on = s.smc & s.dfc;

    // Interrupts: match events pass; stop interrupt muted in wakeup mode.
    n.int_req = ADDR_MATCH_EVT | EXT_CODE_EVT |
                (stop_det & STOP_INT_EN & ~s.wakeup_enable);
    n.wake_req = STOP_MODE & s.wakeup_enable & (ADDR_MATCH_EVT | EXT_CODE_EVT);
    if (s.wakeup_enable && (ADDR_MATCH_EVT || EXT_CODE_EVT)) begin
      n.wup_irq_seen = 1'b1;
    end

    // Master clock timing: low phase, then high phase, counted in cycles.
    hold_tgt = s.wl[7:2];
    n.hold_done = 1'b0;
    case (s.cg)
      CG_IDLE: begin
        n.sda_pull = DATA_PULL_LOW;
        if (CTRL_ENABLE && MASTER_CLK_RUN) begin
          n.cg = CG_LOW;
          n.cg_cnt = 8'h01;
          n.hold_cnt = 6'h00;
          n.hold_done = (hold_tgt == 6'h00);
          if (hold_tgt == 6'h00) begin
            n.sda_pull = DATA_PULL_LOW;
          end
        end
      end
      CG_LOW: begin
        // Data may change only once the hold time has run out.
        if (s.hold_cnt != hold_tgt) begin
          n.hold_cnt = s.hold_cnt + 6'h01;
          if (s.hold_cnt + 6'h01 == hold_tgt) begin
            n.hold_done = 1'b1;
            n.sda_pull = DATA_PULL_LOW;
          end
        end
        if (s.cg_cnt >= s.wl) begin
          n.cg = MASTER_CLK_RUN ? CG_HIGH : CG_IDLE;
          n.cg_cnt = 8'h01;
        end else begin
          n.cg_cnt = s.cg_cnt + 8'h01;
        end
      end
      CG_HIGH: begin
        // High time counts only while the line is really high.
        if (s.cg_cnt >= s.wh) begin
          n.cg = MASTER_CLK_RUN ? CG_LOW : CG_IDLE;
          n.cg_cnt = 8'h01;
          n.hold_cnt = 6'h00;
          n.hold_done = (hold_tgt == 6'h00);
        end else if (s.scl_s2) begin
          n.cg_cnt = s.cg_cnt + 8'h01;
        end
      end
      default: begin
        n.cg = CG_IDLE;
      end
    endcase
    if (!CTRL_ENABLE) begin
      n.cg = CG_IDLE;
      n.sda_pull = 1'b0;
    end

    // Open-drain drive; a disabled controller pulls both lines low.
    n.scl_oe = ~n.port6[`IFMWC_P_SCL] &
               (~CTRL_ENABLE | (n.cg == CG_LOW));
    n.sda_oe = ~n.port6[`IFMWC_P_SDA] &
               (~CTRL_ENABLE | n.sda_pull);

    // Read data from the state after this cycle's updates.
    fl = {n.fail, n.busy, 4'h0, n.ise, n.rsv};
    md = {n.wakeup_enable, 1'b0, n.cld, n.dad, n.smc, n.dfc, 2'h0};
    if (RD) begin
      case (ADDR)
        `IFMWC_ADDR_FLAG: n.rdata = fl;
        `IFMWC_ADDR_MODE: n.rdata = md;
        `IFMWC_ADDR_WL: n.rdata = n.wl;
        `IFMWC_ADDR_WH: n.rdata = n.wh;
        `IFMWC_ADDR_PORT6: n.rdata = n.port6;
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '{port6: `IFMWC_RST_PORT6, wl: `IFMWC_RST_WL,
             wh: `IFMWC_RST_WH, scl_s1: 1'b1, scl_s2: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, cg: CG_IDLE,
             scl_oe: 1'b0, sda_oe: 1'b0, default: '0};
    end else begin
      s <= n;
    end
  end

  // Outputs come from the state register; the pin output levels are tied low.
  assign RDATA = s.rdata;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = s.scl_oe;
  assign SDA_OE = s.sda_oe;
  assign BUS_BUSY = s.busy;
  assign START_ALLOWED = s.start_allowed;
  assign RESERVATION_EN = ~s.rsv;
  assign FAST_MODE = s.smc;
  assign DATA_HOLD_DONE = s.hold_done;
  assign INT_REQ = s.int_req;
  assign WAKEUP_REQ = s.wake_req;
endmodule : ifmwc_top

// File: ifmwc_chk_sva.sv
// Checker for read-back, pin drive, flag clearing and pulse rules.
`timescale 1ns/1ps
`include "ifmwc_cfg.svh"
module ifmwc_chk import ifmwc_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CTRL_ENABLE,
  input wire logic SCL_OUT,
  input wire logic SDA_OUT,
  input wire logic BUS_BUSY,
  input wire logic START_ALLOWED,
  input wire logic FAST_MODE,
  input wire logic RESERVATION_EN,
  input wire logic INT_REQ,
  input wire logic WAKEUP_REQ
);
  // Every check runs on the peripheral clock and rests during reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  chk_flag_zero_bits: assert property (
    RD && ADDR == `IFMWC_ADDR_FLAG |=> RDATA[5:2] == 4'h0)
    else $error("flag register bits 5 to 2 not zero");
  chk_port_fixed_ones: assert property (
    RD && ADDR == `IFMWC_ADDR_PORT6 |=> RDATA[7:2] == 6'h3f)
    else $error("direction register upper bits not one");
  chk_unmapped_read: assert property (
    RD && ADDR == 16'h0000 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (
    !RD |=> $stable(RDATA))
    else $error("read data moved without a read");
  chk_open_drain: assert property (
    !SCL_OUT && !SDA_OUT)
    else $error("pin output level not low");
  chk_mode_frozen: assert property (
    CTRL_ENABLE && $past(CTRL_ENABLE) |->
    $stable(FAST_MODE) && $stable(RESERVATION_EN))
    else $error("mode changed while enabled");
  chk_idle_clear: assert property (
    (!CTRL_ENABLE) [*3] |-> !BUS_BUSY && !START_ALLOWED)
    else $error("busy or start allowed while disabled");
  chk_level_zero: assert property (
    (!CTRL_ENABLE) [*3] ##0 (RD && ADDR == `IFMWC_ADDR_MODE) |=>
    RDATA[5:4] == 2'h0)
    else $error("line levels shown while disabled");
  chk_int_pulse: assert property (
    INT_REQ |=> !INT_REQ)
    else $error("interrupt request longer than a cycle");
  chk_wake_pulse: assert property (
    WAKEUP_REQ |=> !WAKEUP_REQ)
    else $error("wakeup request longer than a cycle");
endmodule : ifmwc_chk

bind ifmwc_top ifmwc_chk ifmwc_chk_inst (.CLK, .RST_B, .ADDR, .RD, .RDATA,
  .CTRL_ENABLE, .SCL_OUT, .SDA_OUT, .BUS_BUSY, .START_ALLOWED, .FAST_MODE,
  .RESERVATION_EN, .INT_REQ, .WAKEUP_REQ);

// File: ifmwc_peer.sv
// Far-side bus party: pull-up wiring and start and stop generation.
`timescale 1ns/1ps
module ifmwc_peer import ifmwc_pkg::*; (
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  output logic scl,
  output logic sda
);
  logic scl_low = 1'h0; // Peer pulls the clock line low.
  logic sda_low = 1'h0; // Peer pulls the data line low.

  // Lines are wired-AND with a pull-up, so any party can pull low.
  assign scl = ~(dut_scl_oe | scl_low);
  assign sda = ~(dut_sda_oe | sda_low);

  // One slow bus step, long enough for the filter to pass it.
  task automatic step(input logic c, input logic d);
    #1000;
    scl_low = c;
    sda_low = d;
  endtask : step

  // Data falls while the clock is high, begun only from an idle bus.
  task automatic send_start;
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
  endtask : send_start

  // Data rises while the clock is high, then the bus is left idle.
  task automatic send_stop;
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
    step(1'h0, 1'h0);
    // Let the final data edge pass the link filter before returning.
    #1000;
  endtask : send_stop
endmodule : ifmwc_peer

// File: ifmwc_tb.sv
// Self-checking bench: register tasks, bus peer and rule scenarios.
`timescale 1ns/1ps
`include "ifmwc_cfg.svh"
module testbench import ifmwc_pkg::*; ;
  localparam logic [15:0] a_p6 = `IFMWC_ADDR_PORT6;
  localparam logic [15:0] a_mode = `IFMWC_ADDR_MODE;
  localparam logic [15:0] a_flag = `IFMWC_ADDR_FLAG;
  localparam logic [15:0] a_wl = `IFMWC_ADDR_WL;
  localparam logic [15:0] a_wh = `IFMWC_ADDR_WH;
  logic CLK = 1'h0, LINK_CLK = 1'h0, RST_B = 1'h0, WR = 1'h0, RD = 1'h0;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00, WMASK = 8'h00, RDATA;
  logic CTRL_ENABLE = 1'h0, START_REQ = 1'h0, START_FAIL = 1'h0;
  logic STOP_MODE = 1'h0, ADDR_MATCH_EVT = 1'h0, EXT_CODE_EVT = 1'h0;
  logic STOP_INT_EN = 1'h0, MASTER_CLK_RUN = 1'h0, DATA_PULL_LOW = 1'h0;
  logic SCL_IN, SCL_OUT, SCL_OE, SDA_IN, SDA_OUT, SDA_OE, BUS_BUSY;
  logic START_ALLOWED, RESERVATION_EN, FAST_MODE, DATA_HOLD_DONE;
  logic INT_REQ, WAKEUP_REQ;
  int n_fail = 0, tests_run = 0, n_int = 0, n_wake = 0, n, h, i;

  // Peripheral clock of 25 ns.
  always #12.5 CLK = ~CLK;
  // Link clock of 125 ns, offset so its edges never meet the main clock's edges.
  initial begin
    #17;
    forever #62.5 LINK_CLK = ~LINK_CLK;
  end

  ifmwc_top ifmwc_top_inst (.CLK, .RST_B, .LINK_CLK, .ADDR, .WDATA, .WMASK,
    .WR, .RD, .RDATA, .CTRL_ENABLE, .START_REQ, .START_FAIL, .STOP_MODE,
    .ADDR_MATCH_EVT, .EXT_CODE_EVT, .STOP_INT_EN, .MASTER_CLK_RUN,
    .DATA_PULL_LOW, .SCL_IN, .SCL_OUT, .SCL_OE, .SDA_IN, .SDA_OUT, .SDA_OE,
    .BUS_BUSY, .START_ALLOWED, .RESERVATION_EN, .FAST_MODE, .DATA_HOLD_DONE,
    .INT_REQ, .WAKEUP_REQ);
  ifmwc_peer ifmwc_peer_inst (.dut_scl_oe(SCL_OE), .dut_sda_oe(SDA_OE),
    .scl(SCL_IN), .sda(SDA_IN));

  // Counts the one-cycle interrupt and wakeup pulses.
  always @(posedge CLK) begin
    if (INT_REQ === 1'h1) n_int++;
    if (WAKEUP_REQ === 1'h1) n_wake++;
  end

  // Waits k edges, then settles just after the last one.
  task tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : tick

  // Compares one value and reports a mismatch at once.
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // One register write; a spare cycle keeps strobes from merging.
  task wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    ADDR = a;
    WDATA = d;
    WMASK = m;
    WR = 1'h1;
    tick(1);
    WR = 0;
    tick(1);
  endtask : wr

  // One register read; the data is taken at the edge that takes RD.
  task rd(input logic [15:0] a, input logic [7:0] e);
    ADDR = a;
    RD = 1'h1;
    tick(1);
    RD = 1'h0;
    chk($sformatf("register %h", a), e, RDATA);
    tick(1);
  endtask : rd

  task done(input string s);
    $display("test %s finished", s);
  endtask : done

  // Prints the counts and the verdict, then ends the run.
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // Main sequence of scenarios.
  initial begin
    repeat (6) @(posedge CLK);
    #1 RST_B = 1'h1;
    tick(1);
    rd(a_p6, 8'hff);
    rd(a_mode, 8'h00);
    rd(a_flag, 8'h00);
    rd(a_wl, 8'hff);
    rd(a_wh, 8'hff);
    rd(16'h0000, 8'h00);
    done("reset");
    wr(a_flag, 8'hff, 8'hff);
    rd(a_flag, 8'h03);
    wr(a_flag, 8'h01, 8'hff);
    chk("reservation enable", 8'h00, {7'h00, RESERVATION_EN});
    wr(a_mode, 8'h7f, 8'hff);
    rd(a_mode, 8'h0c);
    chk("fast mode", 8'h01, {7'h00, FAST_MODE});
    wr(a_wl, 8'h0c, 8'hff);
    wr(a_wh, 8'h03, 8'hff);
    wr(a_p6, 8'h00, 8'hff);
    rd(a_p6, 8'hfc);
    chk("pin pull while disabled", 8'h03, {6'h00, SDA_OE, SCL_OE});
    wr(a_p6, 8'hff, 8'hff);
    done("setup");
    CTRL_ENABLE = 1'h1;
    tick(2);
    chk("busy", 8'h01, {7'h00, BUS_BUSY});
    chk("start allowed", 8'h00, {7'h00, START_ALLOWED});
    START_FAIL = 1'h1;
    tick(1);
    START_FAIL = 1'h0;
    tick(1);
    rd(a_flag, 8'hc1);
    START_REQ = 1'h1;
    tick(1);
    START_REQ = 1'h0;
    tick(20);
    rd(a_flag, 8'h41);
    wr(a_flag, 8'h02, 8'hff);
    wr(a_mode, 8'h00, 8'h0c);
    wr(a_wl, 8'hff, 8'hff);
    rd(a_flag, 8'h41);
    rd(a_mode, 8'h3c);
    rd(a_wl, 8'h0c);
    ifmwc_peer_inst.send_start();
    tick(20);
    ifmwc_peer_inst.send_stop();
    tick(20);
    chk("busy after stop", 8'h00, {7'h00, BUS_BUSY});
    chk("start allowed", 8'h01, {7'h00, START_ALLOWED});
    done("enable");
    wr(a_p6, 8'h00, 8'hff);
    MASTER_CLK_RUN = 1'h1;
    for (i = 0; i < 50 && SCL_OE !== 1'h1; i++) tick(1);
    n = 0;
    h = 0;
    while (SCL_OE === 1'h1 && n < 300) begin
      n++;
      if (DATA_HOLD_DONE === 1'h1) h++;
      tick(1);
    end
    MASTER_CLK_RUN = 1'h0;
    chk("low width", 8'h0c, n[7:0]);
    chk("hold pulses", 8'h01, h[7:0]);
    tick(40);
    done("master clock");
    STOP_MODE = 1'h1;
    STOP_INT_EN = 1'h1;
    wr(a_mode, 8'h80, 8'h80);
    ifmwc_peer_inst.send_stop();
    tick(20);
    chk("stop interrupt", 8'h00, n_int[7:0]);
    ADDR_MATCH_EVT = 1'h1;
    tick(1);
    ADDR_MATCH_EVT = 1'h0;
    tick(10);
    chk("match interrupt", 8'h01, n_int[7:0]);
    chk("wakeup", 8'h01, n_wake[7:0]);
    wr(a_mode, 8'h00, 8'h80);
    wr(a_mode, 8'h80, 8'h80);
    wr(a_mode, 8'h00, 8'h80);
    chk("master blocked", 8'h00, {7'h00, START_ALLOWED});
    STOP_MODE = 1'h0;
    ifmwc_peer_inst.send_stop();
    tick(20);
    chk("stop interrupt", 8'h02, n_int[7:0]);
    chk("master unblocked", 8'h01, {7'h00, START_ALLOWED});
    wr(a_p6, 8'hff, 8'hff);
    done("wakeup");
    CTRL_ENABLE = 1'h0;
    tick(3);
    rd(a_mode, 8'h0c);
    chk("busy disabled", 8'h00, {7'h00, BUS_BUSY});
    wr(a_flag, 8'h02, 8'hff);
    CTRL_ENABLE = 1'h1;
    tick(2);
    chk("busy", 8'h00, {7'h00, BUS_BUSY});
    chk("start allowed", 8'h01, {7'h00, START_ALLOWED});
    ifmwc_peer_inst.send_start();
    tick(20);
    rd(a_flag, 8'h40);
    ifmwc_peer_inst.send_stop();
    tick(20);
    done("initial start");
    complete_run();
  end

  // Watchdog: the scenarios need well under a millisecond.
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule : testbench
